// file: rtl/hwc_pkg.sv
// constants, states and register map for the halt mode wake-up controller
// assumes a single 100 MHz ref_clk domain and an AXI4-Lite register master
//
// Overview of operation
// RQ1: halt with both enables clear enters plain halt.
// RQ2: halt with realtime irq enable set, auto wake clear, enters active halt.
// RQ3: halt with auto wake set, realtime enable clear, enters rc timed halt.
// RQ4: plain halt exit by interrupt or reset restarts oscillator, waits 256/4096 cycles.
// RQ5: entering any halt forces condition code interrupt level bits to 10b.
// RQ6: plain halt stops main oscillator and all peripheral clocks.
// RQ7: halt with watchdog enabled and halt option clear issues watchdog reset.
// RQ8: active halt keeps only main oscillator and realtime base counter running.
// RQ9: active halt exits on realtime or wake interrupt; delay only on reset.
// RQ10: active halt never causes a watchdog reset on halt instruction.
// RQ11: rc timed halt runs rc oscillator, fixed divider, prescaler; sets flag, interrupt.
// RQ12: auto wake turns main oscillator on and waits stabilisation before service.
// RQ13: reading wake control status clears the wake flag and its interrupt.
// RQ14: measure bit in run mode enables rc and routes it to timer capture one.
// RQ15: rc timed halt exits on halt-exit interrupts or reset, like plain halt.
// RQ16: rc timed halt stops main oscillator and all peripheral clocks.
// RQ17: wake interrupt service pushes condition code and sets software priority level.
// RQ18: prescaler is 8 bits, resets to FFh, 00h forbidden.
// RQ19: halt time is 64 times prescaler rc periods plus rc start-up.
// RQ20: reset together with wake interrupt gives reset priority.
package hwc_pkg;
  // ********
  // register map
  // ********
  localparam logic [7:0] REG_WAKE_CTRL_STATUS = 8'h2B;
  localparam logic [7:0] REG_WAKE_PRESCALER   = 8'h2C;
  localparam logic [7:0] REG_MODE_CTRL        = 8'h30;
  localparam logic [7:0] REG_MODE_STATUS      = 8'h34;
  localparam logic [7:0] WAKE_PRESCALER_RST   = 8'hFF;
  localparam logic [7:0] WAKE_PRESCALER_BAD   = 8'h00;
  localparam int         BIT_AUTO_WAKE        = 0;
  localparam int         BIT_RC_MEASURE       = 1;
  localparam int         BIT_WAKE_FLAG        = 2;
  localparam int         BIT_RTC_IRQ_EN       = 0;
  localparam int         BIT_LONG_DELAY       = 1;
  localparam int         BIT_WDG_HALT_OPT     = 2;
  localparam logic [1:0] LEVEL_HALT_ENTRY     = 2'b10;
  localparam logic [1:0] AXI_OKAY             = 2'b00;
  localparam logic [1:0] AXI_SLVERR           = 2'b10;
  // ********
  // timing
  // ********
  localparam int SHORT_DELAY_CYC = 256;
  localparam int LONG_DELAY_CYC  = 4096;
  localparam int RC_FIXED_DIV    = 64;
  localparam int RC_START_CYC    = 16;

  typedef enum logic [2:0] {
    ST_RUN, ST_HALT, ST_ACTIVE_HALT, ST_RC_HALT, ST_STABILISE, ST_SERVICE
  } hwc_state_t;
endpackage

// file: rtl/hwc_sync.sv
// two flop synchroniser for one level
// assumes the input may change at any time relative to ref_clk
`timescale 1ns/1ps
module hwc_sync (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage1_q;
  logic stage1_d;
  logic sync_d;

  always_comb
  begin
    stage1_d = async_in;
    sync_d   = stage1_q;
    if (!rst_b)
    begin
      stage1_d = 1'b0;
      sync_d   = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    stage1_q <= stage1_d;
    sync_out <= sync_d;
  end
endmodule // hwc_sync

// file: rtl/halt_wake_ctrl.sv
// halt, active halt and rc timed halt sequencer with axi4-lite registers
// assumes cpu signals are on ref_clk; the rc clock arrives as a pin level
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module halt_wake_ctrl #(
  parameter int LONG_DELAY = hwc_pkg::LONG_DELAY_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        halt_exec,
  input  wire logic        watchdog_enabled,
  input  wire logic        halt_exit_irq,
  input  wire logic        rtc_irq,
  input  wire logic        irq_pending,
  input  wire logic        ext_reset,
  input  wire logic        wake_rc_clock,
  input  wire logic        cc_push_ack,
  input  wire logic [1:0]  service_level,
  output logic             main_osc_on,
  output logic             periph_clk_en,
  output logic             rtc_clk_en,
  output logic             rc_osc_on,
  output logic             timer_capture_input_one,
  output logic             cpu_run,
  output logic             force_cc_level,
  output logic [1:0]       cc_level,
  output logic             cc_push,
  output logic             fetch_reset_vector,
  output logic             service_irq,
  output logic             wake_irq,
  output logic             watchdog_reset
);
  // ********
  // pin synchronisers
  // ********
  logic rcSync;
  logic resetSync;
  hwc_sync uRcSync (.ref_clk(ref_clk), .rst_b(rst_b), .async_in(wake_rc_clock),
                    .sync_out(rcSync));
  hwc_sync uRstSync (.ref_clk(ref_clk), .rst_b(rst_b), .async_in(ext_reset),
                     .sync_out(resetSync));

  // ********
  // state
  // ********
  hwc_pkg::hwc_state_t state_q, state_d;
  logic        autoWake_q, autoWake_d;
  logic        rcMeasure_q, rcMeasure_d;
  logic        wakeFlag_q, wakeFlag_d;
  logic [7:0]  prescaler_q, prescaler_d;
  logic        rtcIrqEn_q, rtcIrqEn_d;
  logic        longDelay_q, longDelay_d;
  logic        wdgHaltOpt_q, wdgHaltOpt_d;
  logic [15:0] delayCnt_q, delayCnt_d;
  logic [5:0]  divCnt_q, divCnt_d;
  logic [7:0]  preCnt_q, preCnt_d;
  logic [4:0]  startCnt_q, startCnt_d;
  logic        rcPrev_q, rcPrev_d;
  logic        byReset_q, byReset_d;
  logic        awHave_q, awHave_d, wHave_q, wHave_d;
  logic [7:0]  awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic        wStrb0_q, wStrb0_d;
  logic        bValid_q, bValid_d, rValid_q, rValid_d;
  logic [1:0]  bResp_q, bResp_d, rResp_q, rResp_d;
  logic [31:0] rData_q, rData_d;
  logic        awReady_q, awReady_d, wReady_q, wReady_d, arReady_q, arReady_d;
  logic        mainOsc_q, mainOsc_d, perClk_q, perClk_d, rtcClk_q, rtcClk_d;
  logic        rcOn_q, rcOn_d, capIn_q, capIn_d, cpuRun_q, cpuRun_d;
  logic        forceCc_q, forceCc_d, ccPush_q, ccPush_d;
  logic [1:0]  ccLevel_q, ccLevel_d;
  logic        fetchRst_q, fetchRst_d, svcIrq_q, svcIrq_d;
  logic        wakeIrq_q, wakeIrq_d, wdgRst_q, wdgRst_d;

  logic        rcEdge;
  logic        doWrite;
  logic        readClear;
  logic        wakeSet;
  logic [15:0] delayLoad;

  always_comb
  begin
    state_d      = state_q;
    autoWake_d   = autoWake_q;
    rcMeasure_d  = rcMeasure_q;
    prescaler_d  = prescaler_q;
    rtcIrqEn_d   = rtcIrqEn_q;
    longDelay_d  = longDelay_q;
    wdgHaltOpt_d = wdgHaltOpt_q;
    delayCnt_d   = delayCnt_q;
    divCnt_d     = divCnt_q;
    preCnt_d     = preCnt_q;
    startCnt_d   = startCnt_q;
    byReset_d    = byReset_q;
    rcPrev_d     = rcSync;
    rcEdge       = rcSync & ~rcPrev_q;
    wakeSet      = 1'b0;
    wdgRst_d     = 1'b0;
    forceCc_d    = 1'b0;
    ccPush_d     = 1'b0;
    ccLevel_d    = ccLevel_q;
    fetchRst_d   = 1'b0;
    svcIrq_d     = 1'b0;
    delayLoad    = longDelay_q ? 16'(LONG_DELAY) : 16'(hwc_pkg::SHORT_DELAY_CYC);

    // bus slave: address and data latched in either order
    awHave_d  = awHave_q;
    wHave_d   = wHave_q;
    awAddr_d  = awAddr_q;
    wData_d   = wData_q;
    wStrb0_d  = wStrb0_q;
    bValid_d  = bValid_q;
    bResp_d   = bResp_q;
    rValid_d  = rValid_q;
    rResp_d   = rResp_q;
    rData_d   = rData_q;
    readClear = 1'b0;
    if (s_axi_awvalid && awReady_q)
    begin
      awHave_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wReady_q)
    begin
      wHave_d  = 1'b1;
      wData_d  = s_axi_wdata;
      wStrb0_d = s_axi_wstrb[0];
    end
    doWrite = awHave_q && wHave_q && !bValid_q;
    if (doWrite)
    begin
      awHave_d = 1'b0;
      wHave_d  = 1'b0;
      bValid_d = 1'b1;
      bResp_d  = hwc_pkg::AXI_OKAY;
      unique case (awAddr_q)
        hwc_pkg::REG_WAKE_CTRL_STATUS:
          if (wStrb0_q)
          begin
            autoWake_d  = wData_q[hwc_pkg::BIT_AUTO_WAKE];
            rcMeasure_d = wData_q[hwc_pkg::BIT_RC_MEASURE];
          end
        hwc_pkg::REG_WAKE_PRESCALER:
          // a forbidden zero leaves the prescaler unchanged [RQ18]
          if (wStrb0_q && wData_q[7:0] != hwc_pkg::WAKE_PRESCALER_BAD)
            prescaler_d = wData_q[7:0];
        hwc_pkg::REG_MODE_CTRL:
          if (wStrb0_q)
          begin
            rtcIrqEn_d   = wData_q[hwc_pkg::BIT_RTC_IRQ_EN];
            longDelay_d  = wData_q[hwc_pkg::BIT_LONG_DELAY];
            wdgHaltOpt_d = wData_q[hwc_pkg::BIT_WDG_HALT_OPT];
          end
        hwc_pkg::REG_MODE_STATUS: ;
        default: bResp_d = hwc_pkg::AXI_SLVERR;
      endcase
    end
    if (bValid_q && s_axi_bready)
      bValid_d = 1'b0;
    if (s_axi_arvalid && arReady_q)
    begin
      rValid_d = 1'b1;
      rResp_d  = hwc_pkg::AXI_OKAY;
      rData_d  = 32'h0000_0000;
      unique case (s_axi_araddr)
        hwc_pkg::REG_WAKE_CTRL_STATUS:
        begin
          rData_d[hwc_pkg::BIT_AUTO_WAKE]  = autoWake_q;
          rData_d[hwc_pkg::BIT_RC_MEASURE] = rcMeasure_q;
          rData_d[hwc_pkg::BIT_WAKE_FLAG]  = wakeFlag_q;
          readClear = 1'b1; // [RQ13]
        end
        hwc_pkg::REG_WAKE_PRESCALER: rData_d[7:0] = prescaler_q;
        hwc_pkg::REG_MODE_CTRL:
        begin
          rData_d[hwc_pkg::BIT_RTC_IRQ_EN]   = rtcIrqEn_q;
          rData_d[hwc_pkg::BIT_LONG_DELAY]   = longDelay_q;
          rData_d[hwc_pkg::BIT_WDG_HALT_OPT] = wdgHaltOpt_q;
        end
        hwc_pkg::REG_MODE_STATUS: rData_d[2:0] = state_q;
        default: rResp_d = hwc_pkg::AXI_SLVERR;
      endcase
    end
    if (rValid_q && s_axi_rready)
      rValid_d = 1'b0;
    awReady_d = !awHave_d && !bValid_d;
    wReady_d  = !wHave_d && !bValid_d;
    arReady_d = !rValid_d;

    // ********
    // power mode sequencer
    // ********
    unique case (state_q)
      hwc_pkg::ST_RUN:
        if (halt_exec)
        begin
          forceCc_d = 1'b1; // [RQ5]
          ccLevel_d = hwc_pkg::LEVEL_HALT_ENTRY; // [RQ5]
          if (rtcIrqEn_q && !autoWake_q)
            state_d = hwc_pkg::ST_ACTIVE_HALT; // [RQ2] [RQ10]
          else if (watchdog_enabled && !wdgHaltOpt_q)
            wdgRst_d = 1'b1; // [RQ7]
          else if (autoWake_q && !rtcIrqEn_q)
          begin
            state_d    = hwc_pkg::ST_RC_HALT; // [RQ3]
            divCnt_d   = '0;
            preCnt_d   = '0;
            startCnt_d = '0;
          end
          else
            state_d = hwc_pkg::ST_HALT; // [RQ1]
        end
      hwc_pkg::ST_HALT, hwc_pkg::ST_ACTIVE_HALT, hwc_pkg::ST_RC_HALT:
      begin
        if (state_q == hwc_pkg::ST_RC_HALT && rcEdge)
        begin
          // start-up time first, then 64 rc periods per prescaler step [RQ19]
          if (startCnt_q != 5'(hwc_pkg::RC_START_CYC))
            startCnt_d = startCnt_q + 5'd1;
          else if (divCnt_q != 6'(hwc_pkg::RC_FIXED_DIV - 1))
            divCnt_d = divCnt_q + 6'd1; // [RQ11]
          else
          begin
            divCnt_d = '0;
            preCnt_d = preCnt_q + 8'd1;
            if (preCnt_q + 8'd1 == prescaler_q)
              wakeSet = 1'b1; // [RQ11]
          end
        end
        if (resetSync)
        begin
          // reset wins over any simultaneous wake source [RQ20]
          byReset_d  = 1'b1;
          state_d    = hwc_pkg::ST_STABILISE; // [RQ4] [RQ9] [RQ15]
          delayCnt_d = delayLoad;
        end
        else if (state_q == hwc_pkg::ST_ACTIVE_HALT && (rtc_irq || halt_exit_irq || irq_pending))
        begin
          // no stabilisation: oscillator never stopped [RQ9]
          byReset_d = 1'b0;
          state_d   = hwc_pkg::ST_SERVICE;
        end
        else if (state_q != hwc_pkg::ST_ACTIVE_HALT && (halt_exit_irq || irq_pending || wakeSet))
        begin
          byReset_d  = 1'b0;
          state_d    = hwc_pkg::ST_STABILISE; // [RQ4] [RQ12] [RQ15]
          delayCnt_d = delayLoad;
        end
      end
      hwc_pkg::ST_STABILISE:
        if (delayCnt_q == 16'd1)
          state_d = byReset_q ? hwc_pkg::ST_RUN : hwc_pkg::ST_SERVICE;
        else
          delayCnt_d = delayCnt_q - 16'd1;
      hwc_pkg::ST_SERVICE:
      begin
        ccPush_d  = 1'b1; // [RQ17]
        ccLevel_d = service_level; // [RQ17]
        if (cc_push_ack)
        begin
          svcIrq_d = 1'b1;
          state_d  = hwc_pkg::ST_RUN;
        end
      end
      default: state_d = hwc_pkg::ST_RUN;
    endcase
    if (state_q == hwc_pkg::ST_STABILISE && delayCnt_q == 16'd1 && byReset_q)
      fetchRst_d = 1'b1; // [RQ4] [RQ20]

    // set beats a clearing read in the same cycle
    wakeFlag_d = wakeSet ? 1'b1 : (readClear ? 1'b0 : wakeFlag_q); // [RQ13]
    wakeIrq_d  = wakeFlag_d; // [RQ11]

    // clock gating follows the next state
    mainOsc_d = !(state_d == hwc_pkg::ST_HALT || state_d == hwc_pkg::ST_RC_HALT); // [RQ6] [RQ16]
    rtcClk_d  = mainOsc_d; // [RQ8]
    perClk_d  = state_d == hwc_pkg::ST_RUN || state_d == hwc_pkg::ST_SERVICE; // [RQ6] [RQ8] [RQ16]
    cpuRun_d  = state_d == hwc_pkg::ST_RUN || state_d == hwc_pkg::ST_SERVICE;
    // rc runs in timed halt, or for calibration while in run [RQ14]
    rcOn_d    = state_d == hwc_pkg::ST_RC_HALT || (state_d == hwc_pkg::ST_RUN && rcMeasure_d);
    capIn_d   = state_d == hwc_pkg::ST_RUN && rcMeasure_d && rcSync; // [RQ14]

    if (!rst_b)
    begin
      state_d = hwc_pkg::ST_RUN;
      autoWake_d = 1'b0;
      rcMeasure_d = 1'b0;
      wakeFlag_d = 1'b0;
      prescaler_d = hwc_pkg::WAKE_PRESCALER_RST; // [RQ18]
      rtcIrqEn_d = 1'b0;
      longDelay_d = 1'b1;
      wdgHaltOpt_d = 1'b1;
      delayCnt_d = '0;
      divCnt_d = '0;
      preCnt_d = '0;
      startCnt_d = '0;
      rcPrev_d = 1'b0;
      byReset_d = 1'b0;
      awHave_d = 1'b0;
      wHave_d = 1'b0;
      awAddr_d = '0;
      wData_d = '0;
      wStrb0_d = 1'b0;
      bValid_d = 1'b0;
      bResp_d = hwc_pkg::AXI_OKAY;
      rValid_d = 1'b0;
      rResp_d = hwc_pkg::AXI_OKAY;
      rData_d = '0;
      awReady_d = 1'b0;
      wReady_d = 1'b0;
      arReady_d = 1'b0;
      mainOsc_d = 1'b1;
      perClk_d = 1'b1;
      rtcClk_d = 1'b1;
      rcOn_d = 1'b0;
      capIn_d = 1'b0;
      cpuRun_d = 1'b1;
      forceCc_d = 1'b0;
      ccPush_d = 1'b0;
      ccLevel_d = '0;
      fetchRst_d = 1'b0;
      svcIrq_d = 1'b0;
      wakeIrq_d = 1'b0;
      wdgRst_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    state_q <= state_d;       autoWake_q <= autoWake_d;   rcMeasure_q <= rcMeasure_d;
    wakeFlag_q <= wakeFlag_d; prescaler_q <= prescaler_d; rtcIrqEn_q <= rtcIrqEn_d;
    longDelay_q <= longDelay_d; wdgHaltOpt_q <= wdgHaltOpt_d; delayCnt_q <= delayCnt_d;
    divCnt_q <= divCnt_d;     preCnt_q <= preCnt_d;       startCnt_q <= startCnt_d;
    rcPrev_q <= rcPrev_d;     byReset_q <= byReset_d;     awHave_q <= awHave_d;
    wHave_q <= wHave_d;       awAddr_q <= awAddr_d;       wData_q <= wData_d;
    wStrb0_q <= wStrb0_d;     bValid_q <= bValid_d;       bResp_q <= bResp_d;
    rValid_q <= rValid_d;     rResp_q <= rResp_d;         rData_q <= rData_d;
    awReady_q <= awReady_d;   wReady_q <= wReady_d;       arReady_q <= arReady_d;
    mainOsc_q <= mainOsc_d;   perClk_q <= perClk_d;       rtcClk_q <= rtcClk_d;
    rcOn_q <= rcOn_d;         capIn_q <= capIn_d;         cpuRun_q <= cpuRun_d;
    forceCc_q <= forceCc_d;   ccPush_q <= ccPush_d;       ccLevel_q <= ccLevel_d;
    fetchRst_q <= fetchRst_d; svcIrq_q <= svcIrq_d;       wakeIrq_q <= wakeIrq_d;
    wdgRst_q <= wdgRst_d;
  end

  assign s_axi_awready           = awReady_q;
  assign s_axi_wready            = wReady_q;
  assign s_axi_bresp             = bResp_q;
  assign s_axi_bvalid            = bValid_q;
  assign s_axi_arready           = arReady_q;
  assign s_axi_rdata             = rData_q;
  assign s_axi_rresp             = rResp_q;
  assign s_axi_rvalid            = rValid_q;
  assign main_osc_on             = mainOsc_q;
  assign periph_clk_en           = perClk_q;
  assign rtc_clk_en              = rtcClk_q;
  assign rc_osc_on               = rcOn_q;
  assign timer_capture_input_one = capIn_q;
  assign cpu_run                 = cpuRun_q;
  assign force_cc_level          = forceCc_q;
  assign cc_level                = ccLevel_q;
  assign cc_push                 = ccPush_q;
  assign fetch_reset_vector      = fetchRst_q;
  assign service_irq             = svcIrq_q;
  assign wake_irq                = wakeIrq_q;
  assign watchdog_reset          = wdgRst_q;
endmodule // halt_wake_ctrl

// file: test/hwc_cpu_model.sv
// cpu side model: acknowledges the condition code push of a wake-up
// assumes cc_push is a level held by the sequencer until acknowledged
`timescale 1ns/1ps
module hwc_cpu_model (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic cc_push,
  input  wire logic slow,
  output logic      cc_push_ack
);
  logic [1:0] waitCnt_q;
  // slow mode stretches the stack push to four cycles
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || !cc_push || cc_push_ack)
    begin
      waitCnt_q   <= 2'h0;
      cc_push_ack <= 1'h0;
    end
    else
    begin
      waitCnt_q   <= waitCnt_q + 2'h1;
      cc_push_ack <= !slow || waitCnt_q == 2'h3;
    end
  end
endmodule // hwc_cpu_model

// file: test/hwc_chk.sv
// port checker for the halt wake-up sequencer
// assumes one ref_clk domain; bound to halt_wake_ctrl at the foot
`timescale 1ns/1ps
module hwc_chk (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic [7:0] s_axi_araddr,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       halt_exec,
  input wire logic       watchdog_enabled,
  input wire logic       cc_push_ack,
  input wire logic       main_osc_on,
  input wire logic       periph_clk_en,
  input wire logic       rtc_clk_en,
  input wire logic       rc_osc_on,
  input wire logic       timer_capture_input_one,
  input wire logic       cpu_run,
  input wire logic       force_cc_level,
  input wire logic [1:0] cc_level,
  input wire logic       cc_push,
  input wire logic       fetch_reset_vector,
  input wire logic       service_irq,
  input wire logic       wake_irq,
  input wire logic       watchdog_reset
);
  logic [12:0] oscWait_q;
  logic [12:0] oscWait_d;
  // cycles with the oscillator up and the cpu held, saturating
  always_comb
  begin
    oscWait_d = oscWait_q + {12'h000, oscWait_q != 13'h1fff};
    if (!main_osc_on || cpu_run)
      oscWait_d = 13'h0000;
  end
  always_ff @(posedge ref_clk)
  begin
    oscWait_q <= rst_b ? oscWait_d : 13'h0000;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  a_halt_clocks_off:
    assert property (!main_osc_on |-> !periph_clk_en && !rtc_clk_en && !cpu_run)
    else $error("clocks run while the oscillator is off");
  a_entry_level_forced:
    assert property (halt_exec && cpu_run && !watchdog_enabled
      |-> ##[1:2] force_cc_level && cc_level == hwc_pkg::LEVEL_HALT_ENTRY)
    else $error("halt entry did not force the interrupt level");
  a_reset_after_delay:
    assert property (fetch_reset_vector |-> oscWait_q >= 13'h00fc)
    else $error("reset vector fetched before stabilisation");
  a_read_clears_flag:
    assert property (s_axi_arvalid && s_axi_arready && cpu_run
      && s_axi_araddr == hwc_pkg::REG_WAKE_CTRL_STATUS |-> ##[1:2] !wake_irq)
    else $error("status read left the wake flag set");
  a_wake_from_rc:
    assert property ($rose(wake_irq) |-> $past(rc_osc_on))
    else $error("wake flag set without the rc oscillator");
  a_push_then_service:
    assert property (cc_push && cc_push_ack |-> ##[1:2] service_irq)
    else $error("no service after the push was acknowledged");
  a_capture_needs_rc:
    assert property (timer_capture_input_one |-> rc_osc_on)
    else $error("capture input toggles with rc oscillator off");
  a_wdog_has_cause:
    assert property (watchdog_reset
      |-> $past(watchdog_enabled) && ($past(halt_exec) || $past(halt_exec, 2)))
    else $error("watchdog reset without a halt");
endmodule // hwc_chk

bind halt_wake_ctrl hwc_chk u_chk (
  .ref_clk, .rst_b, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .halt_exec,
  .watchdog_enabled, .cc_push_ack, .main_osc_on, .periph_clk_en, .rtc_clk_en, .rc_osc_on,
  .timer_capture_input_one, .cpu_run, .force_cc_level, .cc_level, .cc_push,
  .fetch_reset_vector, .service_irq, .wake_irq, .watchdog_reset
);

// file: test/halt_wake_ctrl_tb.sv
// self-checking bench for halt_wake_ctrl with a cpu push model
// assumes hwc_pkg, the design, the model and the checker are compiled first
`timescale 1ns/1ps
module halt_wake_ctrl_tb;
  localparam int         LongCyc = 300;
  localparam logic [7:0] Wcs = hwc_pkg::REG_WAKE_CTRL_STATUS;
  localparam logic [7:0] Wpr = hwc_pkg::REG_WAKE_PRESCALER;
  localparam logic [7:0] Mct = hwc_pkg::REG_MODE_CTRL;
  logic        ref_clk = 1'h0, rst_b = 1'h0, slow = 1'h0, capLast = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, lastData, seed = 32'h0000_1ad7;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, lastResp, cc_level, service_level = 2'h1;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, cc_push_ack, cc_push;
  logic        halt_exec = 1'h0, watchdog_enabled = 1'h0, halt_exit_irq = 1'h0;
  logic        rtc_irq = 1'h0, irq_pending = 1'h0, ext_reset = 1'h0, wake_rc_clock = 1'h0;
  logic        main_osc_on, periph_clk_en, rtc_clk_en, rc_osc_on, timer_capture_input_one;
  logic        cpu_run, force_cc_level, fetch_reset_vector, service_irq, wake_irq;
  logic        watchdog_reset;
  logic [7:0]  rstAddr [4] = '{Wcs, Wpr, Mct, hwc_pkg::REG_MODE_STATUS};
  logic [31:0] rstVal [4] = '{32'h0, 32'hff, 32'h6, 32'h0};
  logic [31:0] mc [4] = '{32'h4, 32'h5, 32'h6, 32'h5};
  logic [31:0] aw [4] = '{32'h0, 32'h0, 32'h1, 32'h1};
  logic [31:0] code [4] = '{32'h1, 32'h2, 32'h3, 32'h1};
  logic [3:0]  clk4 [4] = '{4'h0, 4'ha, 4'h1, 4'h0};
  int          fail_count = 0, comparisons = 0, cyc = 0, t0 = 0, wdogs = 0, capEdges = 0;
  int          pre, lo;

  halt_wake_ctrl #(.LONG_DELAY(LongCyc)) dut (.*);
  hwc_cpu_model cpu (.ref_clk, .rst_b, .cc_push, .slow, .cc_push_ack);

  initial forever #5 ref_clk = ~ref_clk;
  // rc clock stands still unless the design powers the rc oscillator
  initial forever #37 wake_rc_clock = rc_osc_on ? ~wake_rc_clock : 1'h0;
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    capLast <= timer_capture_input_one;
    if (watchdog_reset === 1'h1)
      wdogs <= wdogs + 1;
    if (timer_capture_input_one !== capLast)
      capEdges <= capEdges + 1;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int stabCyc(input logic [31:0] ctrl);
    return ctrl[hwc_pkg::BIT_LONG_DELAY] ? LongCyc : hwc_pkg::SHORT_DELAY_CYC;
  endfunction
  // rc period is 74 ns, so 7.4 ref_clk cycles per rc cycle
  function automatic int rcCyc(input int p);
    return (hwc_pkg::RC_FIXED_DIV * p + hwc_pkg::RC_START_CYC) * 74 / 10;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic checkWin(input int lo, input int hi);
    check({31'h0, cyc - t0 >= lo && cyc - t0 <= hi}, 32'h1);
  endtask
  task automatic waitSig(input int sel);
    while ((({watchdog_reset, wake_irq, fetch_reset_vector, service_irq} >> sel) & 4'h1) !== 4'h1)
      @(posedge ref_clk);
  endtask
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    waitSigBus(1'h1);
  endtask
  // waits for the write or read response
  task automatic waitSigBus(input logic isWrite);
    while (!(isWrite ? s_axi_bvalid : s_axi_rvalid))
      @(posedge ref_clk);
    lastResp = isWrite ? s_axi_bresp : s_axi_rresp;
    lastData = s_axi_rdata;
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic axiRead(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
      @(posedge ref_clk);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    waitSigBus(1'h0);
  endtask
  task automatic haltNow();
    halt_exec <= 1'h1;
    t0 = cyc;
    @(posedge ref_clk);
    halt_exec <= 1'h0;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge ref_clk);
    fail_count++;
    conclude();
  end

  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'h1;
    @(posedge ref_clk);
    // ********
    // registers, refusals, prescaler and rc measurement
    // ********
    foreach (rstAddr[i])
    begin
      axiRead(rstAddr[i]);
      check(lastData, rstVal[i]);
    end
    axiRead(8'h40);
    check(lastResp, hwc_pkg::AXI_SLVERR);
    axiWrite(Wpr, 32'h0);
    axiRead(Wpr);
    check(lastData, 32'hff);
    repeat (4)
    begin
      seed = lfsr(seed);
      pre = (seed[7:0] == 8'h00) ? 1 : int'(seed[7:0]);
      axiWrite(Wpr, 32'(pre));
      axiRead(Wpr);
      check(lastData, 32'(pre));
    end
    pre = int'(seed[1:0]) + 1;
    axiWrite(Wpr, 32'(pre));
    axiWrite(Wcs, 32'h2);
    t0 = capEdges;
    repeat (60) @(posedge ref_clk);
    check({31'h0, capEdges - t0 > 6}, 32'h1);
    // ********
    // each halt mode: entry, clocks, wake-up and delay
    // ********
    for (int i = 0; i < 4; i++)
    begin
      axiWrite(Mct, mc[i]);
      axiWrite(Wcs, aw[i]);
      slow <= i[0];
      haltNow();
      repeat (3) @(posedge ref_clk);
      check({main_osc_on, periph_clk_en, rtc_clk_en, rc_osc_on}, clk4[i]);
      axiRead(hwc_pkg::REG_MODE_STATUS);
      check(lastData, code[i]);
      if (i == 2)
      begin
        waitSig(2);
        checkWin(rcCyc(pre) - 30, rcCyc(pre) + 30);
      end
      halt_exit_irq <= (i == 0);
      irq_pending <= (i == 3);
      rtc_irq <= (i == 1);
      t0 = cyc;
      lo = (i == 1) ? 0 : stabCyc(mc[i]);
      waitSig(0);
      checkWin(lo - 2, lo + 14);
      {halt_exit_irq, rtc_irq, irq_pending} <= 3'h0;
      if (i == 2)
      begin
        axiRead(Wcs);
        check(lastData, 32'h5);
        axiRead(Wcs);
        check(lastData, 32'h1);
      end
    end
    // ********
    // watchdog with halts, reset exit from active halt
    // ********
    watchdog_enabled <= 1'h1;
    axiWrite(Mct, 32'h3);
    axiWrite(Wcs, 32'h0);
    lo = wdogs;
    haltNow();
    repeat (6) @(posedge ref_clk);
    check(wdogs, lo);
    ext_reset <= 1'h1;
    t0 = cyc;
    repeat (4) @(posedge ref_clk);
    ext_reset <= 1'h0;
    rtc_irq <= 1'h1;
    waitSig(1);
    checkWin(LongCyc - 2, LongCyc + 14);
    rtc_irq <= 1'h0;
    axiWrite(Mct, 32'h2);
    haltNow();
    waitSig(3);
    checkWin(1, 4);
    conclude();
  end
endmodule // halt_wake_ctrl_tb
